/* hw/pasc_pkg.sv */
// Purpose: shared constants and types for the power/analog control register bank
// Assumes: 16-bit frames, command code in upper byte, data in lower byte
// Notes:   write codes 0x4x/0x5x, read codes 0x8x/0x9x
package pasc_pkg;
    localparam logic [7:0] PASC_WR_RESERVE_TEST = 8'h42;
    localparam logic [7:0] PASC_RD_RESERVE_TEST = 8'h82;
    localparam logic [7:0] PASC_WR_POWER        = 8'h51;
    localparam logic [7:0] PASC_RD_POWER        = 8'h91;
    localparam logic [7:0] PASC_WR_MUX          = 8'h52;
    localparam logic [7:0] PASC_RD_MUX          = 8'h92;
    localparam logic [7:0] PASC_WR_DCS          = 8'h53;
    localparam logic [7:0] PASC_RD_DCS          = 8'h93;
    localparam logic [7:0] PASC_RSP_WR_HDR      = 8'h2e;
    localparam logic [7:0] PASC_RSP_RD_HDR      = 8'h4e;
    localparam logic [7:0] PASC_RSP_TEST_WR_HDR = 8'h4e;
    localparam int         PASC_BIT_BOOST_OK    = 7;
    localparam int         PASC_BIT_FAULT       = 6;
    localparam int         PASC_BIT_SYNC        = 5;
    localparam int         PASC_BIT_BOOST       = 4;
    localparam int         PASC_BIT_BUCK        = 2;
    localparam int         PASC_BIT_TEST_EN     = 0;
    localparam logic [1:0] PASC_RSV_RESET       = 2'h0;
    localparam logic [4:0] PASC_MUX_RESET       = 5'h00;
    localparam logic [4:0] PASC_MUX_LAST_LOW    = 5'h0f;
    localparam logic [4:0] PASC_MUX_FIRST_DRV   = 5'h11;
    localparam logic [4:0] PASC_MUX_LAST_DRV    = 5'h14;
    localparam logic [5:0] PASC_DCS_RESET       = 6'h00;
    localparam int         PASC_FRAME_BITS      = 16;

    typedef enum logic [2:0]
    {
        PASC_IDLE  = 3'b001,
        PASC_SHIFT = 3'b010,
        PASC_DONE  = 3'b100
    } pasc_link_state_type;

    typedef struct packed
    {
        logic       sync_supply_on;
        logic       boost_on;
        logic       buck_on;
        logic [1:0] reserve_switch_control;
    } pasc_power_type;

    typedef struct packed
    {
        logic boost_ok;
        logic boost_shutdown;
        logic buck_shutdown;
        logic sync_shutdown;
        logic reserve_fault;
        logic dcs_shutdown;
        logic sensor_sync;
    } pasc_status_type;
endpackage : pasc_pkg

/* hw/pasc_regs.sv */
// Purpose: SPI-reached power, reserve test, analog mux and DC sensor bias controls
// Assumes: SPI mode 0, 16-bit frames MSB first, SCK idles low between frames
// Notes:   frame is shifted on the link clock; received words cross by a toggle handshake, the answer is taken as chip select falls
`timescale 1ns/100ps
`default_nettype none
module pasc_regs
    import pasc_pkg::*;
(
    // core clock and resets
    input  wire logic                  I_CORE_CLK,
    input  wire logic                  I_RST_N,
    input  wire logic                  I_SLEEP_RST_N,
    // spi link
    input  wire logic                  I_SPI_SCK,
    input  wire logic                  I_SPI_CS_N,
    input  wire logic                  I_SPI_MOSI,
    output logic                       O_SPI_MISO,
    // analog status
    input  wire pasc_pkg::pasc_status_type I_STATUS,
    input  wire logic [9:0]            I_TEST_ADC,
    input  wire logic                  I_TEST_ADC_VALID,
    input  wire logic                  I_DIAG_CLEAR,
    // power controls
    output pasc_pkg::pasc_power_type   O_POWER,
    output logic                       O_CHARGE_SW,
    output logic                       O_DISCHARGE_SW,
    output logic                       O_TEST_ACTIVE,
    // analog mux and sensor bias
    output logic [4:0]                 O_MUX_CODE,
    output logic                       O_MUX_OE,
    output logic [3:0]                 O_DCS_INPUT,
    output logic [1:0]                 O_DCS_LEVEL
);
    import pasc_pkg::*;

    // link domain: frame shifting on SCK, reset at each frame by chip select
    logic [15:0]             rx_sh_reg;
    logic [15:0]             tx_sh_reg;
    logic [4:0]              bit_cnt_reg;
    logic [15:0]             rx_word_reg;
    logic                    rx_tgl_reg;
    logic [15:0]             rsp_link_reg;
    logic [15:0]             rsp_word_reg;
    wire  logic              link_rst_n = I_RST_N & ~I_SPI_CS_N;

    always_ff @(posedge I_SPI_SCK or negedge link_rst_n)
    begin
        if (!link_rst_n)
        begin
            rx_sh_reg   <= 16'h0000;
            bit_cnt_reg <= 5'h00;
        end
        else
        begin
            rx_sh_reg   <= {rx_sh_reg[14:0], I_SPI_MOSI};
            bit_cnt_reg <= (bit_cnt_reg == 5'h10) ? bit_cnt_reg : bit_cnt_reg + 5'h01;
        end
    end

    // a whole frame is handed over on the 16th edge; short frames are dropped, a long frame hands over its first 16 bits
    wire logic frame_last = (bit_cnt_reg == 5'h0f);

    always_ff @(posedge I_SPI_SCK or negedge I_RST_N)
    begin
        if (!I_RST_N)
        begin
            rx_word_reg <= 16'h0000;
            rx_tgl_reg  <= 1'b0;
        end
        else if (frame_last)
        begin
            rx_word_reg <= {rx_sh_reg[14:0], I_SPI_MOSI};
            rx_tgl_reg  <= ~rx_tgl_reg;
        end
    end

    // sck stops between frames, so the answer is taken as chip select falls;
    // the word has stood for the required frame gap, hence no metastable capture
    always_ff @(negedge I_SPI_CS_N or negedge I_RST_N)
    begin
        if (!I_RST_N)
            rsp_link_reg <= 16'h0000;
        else
            rsp_link_reg <= rsp_word_reg;
    end

    // miso shows rsp_link_reg[15] until the first rising edge, then tx_sh_reg[15], which shifts on falling edges; first bit shown as chip select falls
    always_ff @(negedge I_SPI_SCK or negedge link_rst_n)
    begin
        if (!link_rst_n)
            tx_sh_reg <= 16'h0000;
        else if (bit_cnt_reg == 5'h01)
            tx_sh_reg <= {rsp_link_reg[14:0], 1'b0};
        else
            tx_sh_reg <= {tx_sh_reg[14:0], 1'b0};
    end

    // mode 0 needs the first bit before any sck edge, so miso is a select of two flops
    wire logic miso_next = (bit_cnt_reg == 5'h00) ? rsp_link_reg[15] : tx_sh_reg[15];

    assign O_SPI_MISO = ~I_SPI_CS_N & miso_next;

    // core domain: toggle crossing and input synchronisers
    logic [2:0]              tgl_sync_reg;
    logic [15:0]             cmd_reg;
    logic                    cmd_vld_reg;
    logic [1:0]              sync_meta_reg;
    logic                    sync_q_reg;
    logic                    sync_prev_reg;
    pasc_status_type         st_meta_reg;
    pasc_status_type         st_reg;

    always_ff @(posedge I_CORE_CLK or negedge I_RST_N)
    begin
        if (!I_RST_N)
        begin
            tgl_sync_reg  <= 3'h0;
            cmd_vld_reg   <= 1'b0;
            cmd_reg       <= 16'h0000;
            st_meta_reg   <= '0;
            st_reg        <= '0;
            sync_prev_reg <= 1'b0;
        end
        else
        begin
            tgl_sync_reg  <= {tgl_sync_reg[1:0], rx_tgl_reg};
            cmd_vld_reg   <= tgl_sync_reg[2] ^ tgl_sync_reg[1];
            cmd_reg       <= (tgl_sync_reg[2] ^ tgl_sync_reg[1]) ? rx_word_reg : cmd_reg;
            st_meta_reg   <= I_STATUS;
            st_reg        <= st_meta_reg;
            sync_prev_reg <= st_reg.sensor_sync;
        end
    end

    // command decode; data bits outside each field are don't-care
    wire logic [7:0] code        = cmd_reg[15:8];
    wire logic [7:0] data        = cmd_reg[7:0];
    wire logic       wr_power    = cmd_vld_reg && code == PASC_WR_POWER;
    wire logic       wr_test     = cmd_vld_reg && code == PASC_WR_RESERVE_TEST;
    wire logic       wr_mux      = cmd_vld_reg && code == PASC_WR_MUX;
    wire logic       wr_dcs      = cmd_vld_reg && code == PASC_WR_DCS;
    wire logic       sync_fall   = sync_prev_reg && !st_reg.sensor_sync;

    // control registers
    pasc_power_type  pwr_reg;
    logic [1:0]      rsv_reg;
    logic            fault_reg;
    logic            test_en_reg;
    logic            test_phase_reg;
    logic [7:0]      test_volt_reg;
    logic [4:0]      mux_reg;
    logic [5:0]      dcs_reg;

    always_ff @(posedge I_CORE_CLK or negedge I_RST_N)
    begin
        if (!I_RST_N)
        begin
            pwr_reg.sync_supply_on <= 1'b0;
            pwr_reg.boost_on       <= 1'b0;
            pwr_reg.buck_on        <= 1'b0;
            pwr_reg.reserve_switch_control <= PASC_RSV_RESET;
        end
        else if (wr_power)
        begin
            pwr_reg.sync_supply_on <= data[PASC_BIT_SYNC];
            pwr_reg.boost_on       <= data[PASC_BIT_BOOST];
            pwr_reg.buck_on        <= data[PASC_BIT_BUCK];
            pwr_reg.reserve_switch_control <= data[1:0];
        end
    end

    // reserve switch bits survive internal reset; only the sleep reset restores them
    always_ff @(posedge I_CORE_CLK or negedge I_SLEEP_RST_N)
    begin
        if (!I_SLEEP_RST_N)
            rsv_reg <= PASC_RSV_RESET;
        else if (wr_power)
            rsv_reg <= data[1:0];
    end

    // fault set wins over a clearing write in the same cycle
    always_ff @(posedge I_CORE_CLK or negedge I_RST_N)
    begin
        if (!I_RST_N)
            fault_reg <= 1'b0;
        else if (st_reg.reserve_fault)
            fault_reg <= 1'b1;
        else if (wr_power && data[1:0] == 2'b00)
            fault_reg <= 1'b0;
    end

    always_ff @(posedge I_CORE_CLK or negedge I_RST_N)
    begin
        if (!I_RST_N)
        begin
            test_en_reg    <= 1'b0;
            test_phase_reg <= 1'b0;
            test_volt_reg  <= 8'h00;
            mux_reg        <= PASC_MUX_RESET;
            dcs_reg        <= PASC_DCS_RESET;
        end
        else
        begin
            test_en_reg    <= wr_test ? data[PASC_BIT_TEST_EN] : test_en_reg;
            test_phase_reg <= !test_en_reg ? 1'b0 : (sync_fall ? 1'b1 : test_phase_reg);
            test_volt_reg  <= I_TEST_ADC_VALID ? I_TEST_ADC[9:2] : test_volt_reg;
            mux_reg        <= I_DIAG_CLEAR ? PASC_MUX_RESET : (wr_mux ? data[4:0] : mux_reg);
            dcs_reg        <= (I_DIAG_CLEAR || st_reg.dcs_shutdown) ? PASC_DCS_RESET :
                              (wr_dcs ? data[7:2] : dcs_reg);
        end
    end

    // actual state: latched setting masked by shutdowns
    wire logic act_sync  = pwr_reg.sync_supply_on & ~st_reg.sync_shutdown;
    wire logic act_boost = pwr_reg.boost_on & ~st_reg.boost_shutdown;
    wire logic act_buck  = pwr_reg.buck_on & ~st_reg.buck_shutdown;
    wire logic sw_off    = fault_reg | test_phase_reg;
    wire logic chg_next  = (rsv_reg == 2'b01) & ~sw_off;
    wire logic dis_next  = ((rsv_reg == 2'b10) & ~fault_reg) | (test_phase_reg & ~fault_reg);
    wire logic mux_valid = (mux_reg <= PASC_MUX_LAST_LOW) ||
                           (mux_reg >= PASC_MUX_FIRST_DRV && mux_reg <= PASC_MUX_LAST_DRV);

    wire logic [7:0] power_data = {st_reg.boost_ok, fault_reg, act_sync, act_boost, 1'b0, act_buck,
                                   rsv_reg};
    wire logic [7:0] rsp_data   =
        (code == PASC_WR_POWER || code == PASC_RD_POWER)        ? power_data :
        (code == PASC_WR_RESERVE_TEST)                          ? {7'h00, test_en_reg} :
        (code == PASC_RD_RESERVE_TEST)                          ? test_volt_reg :
        (code == PASC_WR_MUX || code == PASC_RD_MUX)            ? {3'h0, mux_reg} :
        (code == PASC_WR_DCS || code == PASC_RD_DCS)            ? {dcs_reg, 2'b00} : 8'h00;
    wire logic [7:0] rsp_hdr    = code[7] ? PASC_RSP_RD_HDR :
                                  (code == PASC_WR_RESERVE_TEST) ? PASC_RSP_TEST_WR_HDR : PASC_RSP_WR_HDR;

    always_ff @(posedge I_CORE_CLK or negedge I_RST_N)
    begin
        if (!I_RST_N)
        begin
            rsp_word_reg   <= 16'h0000;
            O_POWER        <= '0;
            O_CHARGE_SW    <= 1'b0;
            O_DISCHARGE_SW <= 1'b0;
            O_TEST_ACTIVE  <= 1'b0;
            O_MUX_CODE     <= PASC_MUX_RESET;
            O_MUX_OE       <= 1'b0;
            O_DCS_INPUT    <= 4'h0;
            O_DCS_LEVEL    <= 2'h0;
        end
        else
        begin
            rsp_word_reg   <= {rsp_hdr, rsp_data};
            O_POWER        <= {act_sync, act_boost, act_buck, rsv_reg};
            O_CHARGE_SW    <= chg_next;
            O_DISCHARGE_SW <= dis_next;
            O_TEST_ACTIVE  <= test_en_reg;
            O_MUX_CODE     <= mux_reg;
            O_MUX_OE       <= mux_valid;
            O_DCS_INPUT    <= dcs_reg[5:2];
            O_DCS_LEVEL    <= dcs_reg[1:0];
        end
    end

    // assertions
    property p_fault_clear;
        @(posedge I_CORE_CLK) disable iff (!I_RST_N)
        (wr_power && data[1:0] == 2'b00 && !st_reg.reserve_fault) |=> !fault_reg;
    endproperty
    a_fault_clear: assert property (p_fault_clear) else $error("fault flag not cleared");

    property p_fault_set;
        @(posedge I_CORE_CLK) disable iff (!I_RST_N)
        st_reg.reserve_fault |=> fault_reg ##1 rsp_word_reg[6] || !(code == PASC_RD_POWER);
    endproperty
    a_fault_set: assert property (p_fault_set) else $error("fault flag not reported");

    property p_hold;
        @(posedge I_CORE_CLK) disable iff (!I_RST_N)
        !wr_power |=> $stable(pwr_reg);
    endproperty
    a_hold: assert property (p_hold) else $error("power setting changed without write");

    property p_sync_write;
        @(posedge I_CORE_CLK) disable iff (!I_RST_N)
        (wr_power && !st_reg.sync_shutdown) ##1 !st_reg.sync_shutdown |=> O_POWER.sync_supply_on == $past(data[5], 2);
    endproperty
    a_sync_write: assert property (p_sync_write) else $error("sync supply not following bit 5");

    property p_shutdown;
        @(posedge I_CORE_CLK) disable iff (!I_RST_N)
        st_reg.boost_shutdown |=> !O_POWER.boost_on;
    endproperty
    a_shutdown: assert property (p_shutdown) else $error("boost on during shutdown");

    property p_charge_decode;
        @(posedge I_CORE_CLK) disable iff (!I_RST_N)
        (rsv_reg == 2'b01 && !fault_reg && !test_phase_reg) |=> O_CHARGE_SW && !O_DISCHARGE_SW;
    endproperty
    a_charge_decode: assert property (p_charge_decode) else $error("charge decode wrong");

    sequence s_test_on;
        test_en_reg && sync_fall;
    endsequence
    property p_test_swap;
        @(posedge I_CORE_CLK) disable iff (!I_RST_N)
        s_test_on ##1 (test_en_reg && !fault_reg) |=> !O_CHARGE_SW && O_DISCHARGE_SW;
    endproperty
    a_test_swap: assert property (p_test_swap) else $error("test did not swap switches");

    property p_test_enable;
        @(posedge I_CORE_CLK) disable iff (!I_RST_N)
        wr_test |=> ##1 O_TEST_ACTIVE == $past(data[0], 2);
    endproperty
    a_test_enable: assert property (p_test_enable) else $error("test active not following bit 0");

    property p_mux_hiz;
        @(posedge I_CORE_CLK) disable iff (!I_RST_N)
        (mux_reg == 5'h10 || mux_reg > 5'h14) |=> !O_MUX_OE;
    endproperty
    a_mux_hiz: assert property (p_mux_hiz) else $error("mux driven on unused code");

    property p_mux_clear;
        @(posedge I_CORE_CLK) disable iff (!I_RST_N)
        I_DIAG_CLEAR |=> mux_reg == PASC_MUX_RESET ##1 O_MUX_CODE == PASC_MUX_RESET;
    endproperty
    a_mux_clear: assert property (p_mux_clear) else $error("mux not cleared");
endmodule : pasc_regs
`default_nettype wire

/* verification/pasc_spi_master.sv */
// Purpose: spi master model standing in for the system controller
// Assumes: mode 0, 16-bit frames, 48 ns link clock running only within frames
// Notes:   mosi flips to the inverse of its last bit between frames
`timescale 1ns/100ps
`default_nettype none
module pasc_spi_master
(
    // link outputs
    output logic      o_sck,
    output logic      o_cs_n,
    output logic      o_mosi,
    // link input
    input  wire logic i_miso
);
    initial
    begin
        o_sck  = 1'b0;
        o_cs_n = 1'b1;
        o_mosi = 1'b0;
    end

    // one whole frame, code byte then data byte, msb first
    task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
        rx = 16'h0000;
        #7 o_cs_n = 1'b0;
        for (int i = 15; i >= 0; i--)
        begin
            o_mosi = tx[i];
            // sample just before the rising edge so no race with the device's update
            #24 rx[i] = i_miso;
            o_sck = 1'b1;
            #24 o_sck = 1'b0;
        end
        #24 o_cs_n = 1'b1;
        // a released line must not keep showing the last bit
        o_mosi = ~o_mosi;
    endtask : xfer
endmodule : pasc_spi_master
`default_nettype wire

/* verification/tb_power_analog_spi_controls.sv */
// Purpose: self-checking bench for the power and analog control register bank
// Assumes: 10 MHz core clock, link clock made by the spi model within frames
// Notes:   each frame returns the response of the previous frame
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin err_total++; $display("BAD %0t got %h exp %h", $time, g, e); end end
module tb_power_analog_spi_controls;
    import pasc_pkg::*;
    logic            clk = 1'b0;
    logic            rst_n = 1'b0;
    logic            sleep_n = 1'b0;
    logic            sck, cs_n, mosi, miso;
    pasc_status_type st = '0;
    logic [9:0]      adc = 10'h000;
    logic            adc_v = 1'b0;
    logic            dclr = 1'b0;
    pasc_power_type  pwr;
    logic            chg, dis, tact, moe;
    logic [4:0]      mcode;
    logic [3:0]      dcs_in;
    logic [1:0]      dcs_lv;
    logic [15:0]     rsp;
    int              err_total = 0;
    int              n_tests = 0;

    pasc_regs DUT
    (
        .I_CORE_CLK(clk), .I_RST_N(rst_n), .I_SLEEP_RST_N(sleep_n),
        .I_SPI_SCK(sck), .I_SPI_CS_N(cs_n), .I_SPI_MOSI(mosi), .O_SPI_MISO(miso),
        .I_STATUS(st), .I_TEST_ADC(adc), .I_TEST_ADC_VALID(adc_v), .I_DIAG_CLEAR(dclr),
        .O_POWER(pwr), .O_CHARGE_SW(chg), .O_DISCHARGE_SW(dis), .O_TEST_ACTIVE(tact),
        .O_MUX_CODE(mcode), .O_MUX_OE(moe), .O_DCS_INPUT(dcs_in), .O_DCS_LEVEL(dcs_lv)
    );
    pasc_spi_master u_spi
    (
        .o_sck(sck), .o_cs_n(cs_n), .o_mosi(mosi), .i_miso(miso)
    );

    always #50 clk = ~clk;

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : cyc

    // one frame, then the gap the core needs to apply it and prepare the answer
    task automatic tx(input logic [7:0] code, input logic [7:0] data);
        u_spi.xfer({code, data}, rsp);
        cyc(8);
    endtask : tx

    task automatic done(input string name);
        $display("test %s finished", name);
    endtask : done

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : report_and_stop

    // about 62 frames of 1.6 us each; ten times that is a hang
    initial
    begin
        #1_000_000;
        err_total++;
        report_and_stop();
    end

    initial
    begin
        cyc(8);
        rst_n   <= 1'b1;
        sleep_n <= 1'b1;
        cyc(6);
        `CHK(pwr, 5'h00)
        `CHK(dcs_in, 4'h0)
        `CHK(tact, 1'b0)
        done("reset");
        tx(8'h51, 8'h3f);
        `CHK(pwr, 5'h1f)
        `CHK({dis, chg}, 2'b00)
        tx(8'h91, 8'h00);
        `CHK(rsp, 16'h2e37)
        tx(8'h51, 8'h21);
        `CHK(pwr, 5'h11)
        for (int e = 0; e < 4; e++)
        begin
            tx(8'h51, 8'h34 | 8'(e));
            `CHK(pwr.reserve_switch_control, 2'(e))
            `CHK({dis, chg}, (e == 3) ? 2'b00 : 2'(e))
        end
        tx(8'h51, 8'h35);
        st.reserve_fault <= 1'b1;
        st.boost_ok      <= 1'b1;
        cyc(4);
        st.reserve_fault <= 1'b0;
        tx(8'h91, 8'h00);
        tx(8'h91, 8'h00);
        `CHK(rsp, 16'h4ef5)
        `CHK(rsp[7], 1'b1)
        tx(8'h51, 8'h34);
        tx(8'h91, 8'h00);
        `CHK(rsp, 16'h2eb4)
        // shutdown masks the output but must not wipe the latched request
        st.boost_shutdown <= 1'b1;
        cyc(6);
        `CHK(pwr.boost_on, 1'b0)
        tx(8'h91, 8'h00);
        tx(8'h91, 8'h00);
        `CHK(rsp, 16'h4ea4)
        st.boost_shutdown <= 1'b0;
        st.boost_ok       <= 1'b0;
        cyc(6);
        `CHK(pwr.boost_on, 1'b1)
        tx(8'h51, 8'h36);
        sleep_n <= 1'b0;
        cyc(2);
        sleep_n <= 1'b1;
        cyc(4);
        `CHK(pwr, 5'h1c)
        done("power");
        for (int c = 0; c < 32; c++)
        begin
            tx(8'h52, 8'he0 | 8'(c));
            `CHK(mcode, 5'(c))
            `CHK(moe, 1'((c < 16) || (c > 16 && c < 21)))
        end
        tx(8'h52, 8'he4);
        tx(8'h92, 8'h00);
        `CHK(rsp, 16'h2e04)
        tx(8'h53, 8'h9f);
        `CHK(rsp, 16'h4e04)
        `CHK(dcs_in, 4'h9)
        tx(8'h93, 8'h00);
        `CHK(rsp, 16'h2e9c)
        for (int v = 0; v < 4; v++)
        begin
            tx(8'h53, 8'h13 | 8'(v << 2));
            `CHK(dcs_lv, 2'(v))
        end
        dclr <= 1'b1;
        cyc(1);
        dclr <= 1'b0;
        cyc(4);
        `CHK(mcode, 5'h00)
        `CHK(dcs_in, 4'h0)
        tx(8'h53, 8'h9f);
        st.dcs_shutdown <= 1'b1;
        cyc(6);
        `CHK(dcs_in, 4'h0)
        st.dcs_shutdown <= 1'b0;
        done("mux and sensor");
        tx(8'h51, 8'h35);
        adc   <= 10'h2b6;
        adc_v <= 1'b1;
        cyc(1);
        adc_v <= 1'b0;
        tx(8'h42, 8'hfe);
        `CHK(tact, 1'b0)
        tx(8'h42, 8'h01);
        `CHK(tact, 1'b1)
        `CHK(chg, 1'b1)
        for (int p = 0; p < 2; p++)
        begin
            st.sensor_sync <= 1'b1;
            cyc(4);
            st.sensor_sync <= 1'b0;
            cyc(6);
            `CHK({dis, chg}, 2'b10)
        end
        tx(8'h82, 8'h00);
        `CHK(rsp[15:8], 8'h4e)
        `CHK(rsp[7:0], 8'h01)
        tx(8'h82, 8'h00);
        `CHK(rsp, 16'h4ead)
        tx(8'h42, 8'h00);
        `CHK({tact, dis, chg}, 3'b001)
        rst_n <= 1'b0;
        cyc(2);
        rst_n <= 1'b1;
        cyc(4);
        `CHK(pwr.sync_supply_on, 1'b0)
        `CHK(mcode, 5'h00)
        done("reserve test and reset");
        report_and_stop();
    end
endmodule : tb_power_analog_spi_controls
`default_nettype wire
